// file: verilog/rxd_params.svh
// constants for the receive port misc and debug registers
`ifndef RXD_PARAMS_SVH
`define RXD_PARAMS_SVH
`define RXD_ADDR_FV_MIN        8'hBC
`define RXD_ADDR_PD_DIS        8'hBE
`define RXD_ADDR_DEBUG         8'hD0
`define RXD_RST_FV_MIN         8'h80
`define RXD_RST_PD_DIS         8'h00
`define RXD_RST_DEBUG          8'h00
`define RXD_BIT_ONCE           0
`define RXD_BIT_CONT           1
`define RXD_BIT_BIST           5
`define RXD_DEBUG_WR_MASK      8'h03
`define RXD_DEBUG_RD_MASK      8'h23
`endif

// file: verilog/rxd_pkg.sv
// types for the receive port misc and debug registers
package rxd_pkg;
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rxd_req_type;
    typedef enum logic [1:0] {
        RXD_IDLE   = 2'b00,
        RXD_COUNT  = 2'b01,
        RXD_ACTIVE = 2'b11
    } rxd_fv_state_type;
endpackage

// file: verilog/rxd_pulldown.sv
// pull-down control for one general-purpose pin
`timescale 1ns/1ps
module rxd_pulldown (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic pin_is_output,
    input  wire logic pin_pulldown_off,
    output logic      pulldown_en
);
    logic next_pulldown_en;

    always_comb begin
        next_pulldown_en = !pin_is_output && !pin_pulldown_off;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pulldown_en <= 1'b0;
        end else begin
            pulldown_en <= next_pulldown_en;
        end
    end

    property p_pd_follows;
        @(posedge core_clk) disable iff (reset)
        pin_pulldown_off |=> !pulldown_en;
    endproperty
    a_pd_follows: assert property (p_pd_follows) else $error("pull-down on when off");
endmodule

// file: verilog/rxd_regs.sv
// receive port misc and debug register bank
`timescale 1ns/1ps
`include "rxd_params.svh"
module rxd_regs #(
    parameter int PINS = 8
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    input  wire rxd_pkg::rxd_req_type req,
    output logic [7:0]                rdata,
    output logic                      rvalid,
    input  wire logic                 raw_mode,
    input  wire logic                 frame_active_signal,
    output logic                      frame_start,
    input  wire logic [PINS-1:0]      pin_is_output,
    output logic [PINS-1:0]           pin_pulldown_en,
    input  wire logic                 remote_selftest_in,
    input  wire logic                 return_frame_start,
    output logic                      return_frame_corrupt
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] frame_valid_min_duration;
    logic [7:0] pin_pulldown_disable;
    logic       inject_return_errors_continuous;
    logic       inject_return_error_once;
    logic       bist_meta;
    logic       remote_selftest_active;
    logic [7:0] next_fv_min;
    logic [7:0] next_pd_dis;
    logic       next_cont;
    logic       next_once;
    logic [7:0] next_rdata;
    logic       next_rvalid;
    logic       next_corrupt;
    logic [7:0] debug_view;

    always_comb begin
        debug_view = 8'h00;
        debug_view[`RXD_BIT_BIST] = remote_selftest_active;
        debug_view[`RXD_BIT_CONT] = inject_return_errors_continuous;
        debug_view[`RXD_BIT_ONCE] = inject_return_error_once;
    end

    always_comb begin
        next_fv_min  = frame_valid_min_duration;
        next_pd_dis  = pin_pulldown_disable;
        next_cont    = inject_return_errors_continuous;
        next_once    = inject_return_error_once;
        next_rdata   = rdata;
        next_rvalid  = req.rd_en;
        next_corrupt = 1'b0;
        if (return_frame_start) begin
            next_corrupt = inject_return_errors_continuous || inject_return_error_once;
            next_once    = 1'b0;
        end
        if (req.wr_en) begin
            unique case (req.addr)
                `RXD_ADDR_FV_MIN: next_fv_min = req.wdata;
                `RXD_ADDR_PD_DIS: next_pd_dis = req.wdata;
                `RXD_ADDR_DEBUG: begin
                    next_cont = req.wdata[`RXD_BIT_CONT];
                    if (req.wdata[`RXD_BIT_ONCE]) begin
                        next_once = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (req.rd_en) begin
            unique case (req.addr)
                `RXD_ADDR_FV_MIN: next_rdata = frame_valid_min_duration;
                `RXD_ADDR_PD_DIS: next_rdata = pin_pulldown_disable;
                `RXD_ADDR_DEBUG:  next_rdata = debug_view;
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            frame_valid_min_duration        <= `RXD_RST_FV_MIN;
            pin_pulldown_disable            <= `RXD_RST_PD_DIS;
            inject_return_errors_continuous <= 1'b0;
            inject_return_error_once        <= 1'b0;
            rdata                           <= 8'h00;
            rvalid                          <= 1'b0;
            return_frame_corrupt            <= 1'b0;
        end else begin
            frame_valid_min_duration        <= next_fv_min;
            pin_pulldown_disable            <= next_pd_dis;
            inject_return_errors_continuous <= next_cont;
            inject_return_error_once        <= next_once;
            rdata                           <= next_rdata;
            rvalid                          <= next_rvalid;
            return_frame_corrupt            <= next_corrupt;
        end
    end

    // ----------------------------------------
    // remote self-test status sync
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bist_meta              <= 1'b0;
            remote_selftest_active <= 1'b0;
        end else begin
            bist_meta              <= remote_selftest_in;
            remote_selftest_active <= bist_meta;
        end
    end

    // ----------------------------------------
    // frame-active minimum duration
    // ----------------------------------------
    rxd_pkg::rxd_fv_state_type fv_state;
    rxd_pkg::rxd_fv_state_type next_fv_state;
    logic [7:0] fv_count;
    logic [7:0] next_fv_count;
    logic       next_frame_start;

    always_comb begin
        next_fv_state    = fv_state;
        next_fv_count    = fv_count;
        next_frame_start = 1'b0;
        unique case (fv_state)
            rxd_pkg::RXD_IDLE: begin
                next_fv_count = 8'h00;
                if (frame_active_signal && raw_mode) begin
                    next_fv_state = rxd_pkg::RXD_COUNT;
                    next_fv_count = 8'h01;
                end
            end
            rxd_pkg::RXD_COUNT: begin
                if (!frame_active_signal) begin
                    next_fv_state = rxd_pkg::RXD_IDLE;
                end else if (fv_count >= frame_valid_min_duration) begin
                    next_fv_state    = rxd_pkg::RXD_ACTIVE;
                    next_frame_start = 1'b1;
                end else begin
                    next_fv_count = fv_count + 8'h01;
                end
            end
            rxd_pkg::RXD_ACTIVE: begin
                if (!frame_active_signal) begin
                    next_fv_state = rxd_pkg::RXD_IDLE;
                end
            end
            default: next_fv_state = rxd_pkg::RXD_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fv_state    <= rxd_pkg::RXD_IDLE;
            fv_count    <= 8'h00;
            frame_start <= 1'b0;
        end else begin
            fv_state    <= next_fv_state;
            fv_count    <= next_fv_count;
            frame_start <= next_frame_start;
        end
    end

    // ----------------------------------------
    // pin pull-downs
    // ----------------------------------------
    for (genvar i = 0; i < PINS; i++) begin : g_pd
        rxd_pulldown u_pd (
            .core_clk         (core_clk),
            .reset            (reset),
            .pin_is_output    (pin_is_output[i]),
            .pin_pulldown_off (pin_pulldown_disable[i]),
            .pulldown_en      (pin_pulldown_en[i])
        );
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_fs_needs_min;
        @(posedge core_clk) disable iff (reset)
        frame_start |-> $past(frame_active_signal)
            && $past(fv_count) >= $past(frame_valid_min_duration);
    endproperty
    a_fs_needs_min: assert property (p_fs_needs_min) else $error("early frame start");

    property p_count_resets;
        @(posedge core_clk) disable iff (reset)
        !frame_active_signal |=> fv_state != rxd_pkg::RXD_COUNT || fv_count == 8'h01;
    endproperty
    a_count_resets: assert property (p_count_resets) else $error("count not consecutive");

    property p_pd_on;
        @(posedge core_clk) disable iff (reset)
        (!pin_is_output[0] && !pin_pulldown_disable[0]) |=> pin_pulldown_en[0];
    endproperty
    a_pd_on: assert property (p_pd_on) else $error("pull-down not enabled");

    property p_pd_write;
        @(posedge core_clk) disable iff (reset)
        req.wr_en && req.addr == `RXD_ADDR_PD_DIS |=> pin_pulldown_disable == $past(req.wdata);
    endproperty
    a_pd_write: assert property (p_pd_write) else $error("pull-down reg write lost");

    property p_bist_read;
        @(posedge core_clk) disable iff (reset)
        req.rd_en && req.addr == `RXD_ADDR_DEBUG
            |=> rdata[`RXD_BIT_BIST] == $past(remote_selftest_active);
    endproperty
    a_bist_read: assert property (p_bist_read) else $error("self-test bit wrong");

    property p_cont;
        @(posedge core_clk) disable iff (reset)
        return_frame_start && inject_return_errors_continuous |=> return_frame_corrupt;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous error missed");

    sequence s_once_spent;
        return_frame_corrupt ##0 !inject_return_error_once;
    endsequence
    property p_once_clear;
        @(posedge core_clk) disable iff (reset)
        return_frame_start && inject_return_error_once && !req.wr_en |=> s_once_spent;
    endproperty
    a_once_clear: assert property (p_once_clear) else $error("single error not done");

    property p_reserved;
        @(posedge core_clk) disable iff (reset)
        req.rd_en && req.addr == `RXD_ADDR_DEBUG |=> (rdata & ~`RXD_DEBUG_RD_MASK) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");
endmodule

// file: verif/rxd_remote_model.sv
// behavioural remote serializer: self-test flag and back channel frames
`timescale 1ns/1ps
module rxd_remote_model (
    input  wire logic core_clk,
    output logic      remote_selftest_in,
    output logic      return_frame_start
);
    initial begin
        remote_selftest_in = 1'b0;
        return_frame_start = 1'b0;
    end
    task automatic set_selftest(input logic on);
        @(negedge core_clk);
        remote_selftest_in = on;
    endtask
    task automatic send_frame();
        @(negedge core_clk);
        return_frame_start = 1'b1;
        @(negedge core_clk);
        return_frame_start = 1'b0;
    endtask
endmodule

// file: verif/rx_port_misc_debug_regs_tb.sv
// self-checking bench for the receive port misc and debug registers
`timescale 1ns/1ps
`include "rxd_params.svh"
module rx_port_misc_debug_regs_tb;
    logic                 core_clk, reset, rvalid, raw_mode, frame_active_signal, frame_start;
    rxd_pkg::rxd_req_type req;
    logic [7:0]           rdata, pin_is_output, pin_pulldown_en, dis, out, n;
    logic                 remote_selftest_in, return_frame_start, return_frame_corrupt;
    int                   n_mismatch = 0, cmp_count = 0, cycles = 0, first, pulses, win;
    logic [7:0]           exp_q[$];

    rxd_regs DUT (
        .core_clk             (core_clk),
        .reset                (reset),
        .req                  (req),
        .rdata                (rdata),
        .rvalid               (rvalid),
        .raw_mode             (raw_mode),
        .frame_active_signal  (frame_active_signal),
        .frame_start          (frame_start),
        .pin_is_output        (pin_is_output),
        .pin_pulldown_en      (pin_pulldown_en),
        .remote_selftest_in   (remote_selftest_in),
        .return_frame_start   (return_frame_start),
        .return_frame_corrupt (return_frame_corrupt)
    );
    rxd_remote_model u_remote (
        .core_clk           (core_clk),
        .remote_selftest_in (remote_selftest_in),
        .return_frame_start (return_frame_start)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        cmp_count++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        req = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        exp_q.push_back(e);
        req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(negedge core_clk);
        req = '0;
    endtask
    task automatic frame_chk(input logic e);
        u_remote.send_frame();
        check({7'h00, return_frame_corrupt}, {7'h00, e});
        @(negedge core_clk);
        check({7'h00, return_frame_corrupt}, 8'h00);
    endtask
    // frame-active held for hold edges, frame_start watched for win edges
    task automatic fv_run(input int hold);
        first = -1;
        pulses = 0;
        @(negedge core_clk);
        frame_active_signal = 1'b1;
        for (int i = 0; i < win; i++) begin
            @(negedge core_clk);
            if (i == hold - 1)
                frame_active_signal = 1'b0;
            if (frame_start === 1'b1) begin
                pulses++;
                if (first < 0)
                    first = i;
            end
        end
        frame_active_signal = 1'b0;
    endtask

    // ------------------------------------------------------------
    // clock, read monitor, timeout
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        if (rvalid === 1'b1)
            check(rdata, exp_q.pop_front());
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        req = '0;
        raw_mode = 1'b0;
        frame_active_signal = 1'b0;
        pin_is_output = 8'h00;
        void'($urandom(80));
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        rd(`RXD_ADDR_FV_MIN, `RXD_RST_FV_MIN);
        rd(`RXD_ADDR_PD_DIS, `RXD_RST_PD_DIS);
        rd(`RXD_ADDR_DEBUG, `RXD_RST_DEBUG);
        rd(8'hBD, 8'h00);
        repeat (4) begin
            dis = 8'($urandom);
            out = 8'($urandom);
            wr(`RXD_ADDR_PD_DIS, dis);
            pin_is_output = out;
            repeat (2) @(negedge core_clk);
            check(pin_pulldown_en, ~out & ~dis);
            rd(`RXD_ADDR_PD_DIS, dis);
        end
        wr(`RXD_ADDR_DEBUG, 8'hFC);
        rd(`RXD_ADDR_DEBUG, 8'h00);
        wr(`RXD_ADDR_DEBUG, 8'h01);
        rd(`RXD_ADDR_DEBUG, 8'h01);
        frame_chk(1'b1);
        rd(`RXD_ADDR_DEBUG, 8'h00);
        frame_chk(1'b0);
        wr(`RXD_ADDR_DEBUG, 8'h02);
        repeat (3) frame_chk(1'b1);
        rd(`RXD_ADDR_DEBUG, 8'h02);
        wr(`RXD_ADDR_DEBUG, 8'h00);
        frame_chk(1'b0);
        u_remote.set_selftest(1'b1);
        repeat (4) @(negedge core_clk);
        rd(`RXD_ADDR_DEBUG, 8'h20);
        u_remote.set_selftest(1'b0);
        repeat (4) @(negedge core_clk);
        rd(`RXD_ADDR_DEBUG, 8'h00);
        n = 8'(2 + $urandom % 6);
        win = 2 * n + 4;
        wr(`RXD_ADDR_FV_MIN, n);
        rd(`RXD_ADDR_FV_MIN, n);
        raw_mode = 1'b1;
        fv_run(win);
        check(8'(pulses), 8'h01);
        check({7'h00, first == n || first == n + 1}, 8'h01);
        fv_run(n - 1);
        check(8'(pulses), 8'h00);
        raw_mode = 1'b0;
        fv_run(win);
        check(8'(pulses), 8'h00);
        repeat (4) @(negedge core_clk);
        check(8'(exp_q.size()), 8'h00);
        give_verdict();
    end
endmodule
